// ===== src/rcr_reset_remap.sv
// Reset cause recorder, retention control and low memory mirror with AXI4-Lite access
// Function
// - Mirror bit 0 set maps SRAM at zero
// - Mirror bit 0 cleared maps flash back
// - Every reset clears the mirror bit
// - Mirror bit 4 reads reduced flash size
// - Mirror bit 3 reads reduced SRAM size
// - Mirror bits 2:1 report debug pin use
// - Debug pin use loaded from boot select
// - Boot kernel runs, then jumps to zero if boot mode pin is high
// - Four causes; all zero means external
// - Power-on sets status bit 0
// - Watchdog timeout sets status bit 1
// - Status bit 2 write forces software reset
// - Status bits clear only through clear register, external reset or power-on reset
// - Retention bit 2 keeps analog outputs
// - Retention bit 0 keeps general I/O
// - Retention update needs key, value, key
`timescale 1ns/100ps
module rcr_reset_remap (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        ext_reset_req,
   input  wire logic        wdt_timeout,
   input  wire logic        boot_select_pin,
   input  wire logic        boot_mode_pin,
   input  wire logic        flash_reduced,
   input  wire logic        sram_reduced,
   output logic             core_reset,
   output logic             gpio_reset,
   output logic             dac_reset,
   output logic             kernel_active,
   output logic             user_start,
   output logic [31:0]      user_vector,
   output logic             sram_at_zero,
   output logic [1:0]       debug_pin_select
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic [rcr_pkg::SEL_W-1:0] rcr_sel(input logic [31:0] a);
      logic [31:0] w;
      w = {a[31:2], 2'b00};
      rcr_sel = '0;
      rcr_sel[rcr_pkg::SEL_MIRROR] = (w == rcr_pkg::ADDR_MIRROR);
      rcr_sel[rcr_pkg::SEL_STATUS] = (w == rcr_pkg::ADDR_STATUS);
      rcr_sel[rcr_pkg::SEL_CLEAR]  = (w == rcr_pkg::ADDR_CLEAR);
      rcr_sel[rcr_pkg::SEL_KEY1]   = (w == rcr_pkg::ADDR_KEY1);
      rcr_sel[rcr_pkg::SEL_CFG]    = (w == rcr_pkg::ADDR_CFG);
      rcr_sel[rcr_pkg::SEL_KEY2]   = (w == rcr_pkg::ADDR_KEY2);
   endfunction : rcr_sel

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic                      aw_full_ff;
   logic                      w_full_ff;
   logic [31:0]               aw_addr_ff;
   logic [7:0]                w_data_ff;
   logic                      w_lane_ff;
   logic                      bvalid_ff;
   logic [1:0]                bresp_ff;
   logic                      rvalid_ff;
   logic [1:0]                rresp_ff;
   logic [31:0]               rdata_ff;
   logic                      mirror_ff;
   logic [2:0]                status_ff;
   logic [7:0]                cfg_ff;
   logic [7:0]                pend_ff;
   rcr_pkg::rcr_key_e         key_ff;
   rcr_pkg::rcr_key_e         nxt_key;
   rcr_pkg::rcr_seq_e         seq_ff;
   logic [7:0]                cnt_ff;
   logic                      hold_gpio_ff;
   logic                      hold_dac_ff;
   logic                      boot_smp_ff;
   logic [1:0]                dbg_ff;
   logic                      fl32_ff;
   logic                      sr4_ff;
   logic                      start_ff;
   logic [31:0]               vec_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshakes and write decode
   wire                       aw_hs   = awvalid && awready;
   wire                       w_hs    = wvalid && wready;
   wire                       ar_hs   = arvalid && arready;
   wire                       wr_go   = aw_full_ff && w_full_ff && !bvalid_ff;
   wire [rcr_pkg::SEL_W-1:0]  wr_sel  = rcr_sel(aw_addr_ff);
   wire [rcr_pkg::SEL_W-1:0]  rd_sel  = rcr_sel(araddr);
   wire                       wr_en   = wr_go && w_lane_ff;
   wire                       wr_mir  = wr_en && wr_sel[rcr_pkg::SEL_MIRROR];
   wire                       wr_sta  = wr_en && wr_sel[rcr_pkg::SEL_STATUS];
   wire                       wr_clr  = wr_en && wr_sel[rcr_pkg::SEL_CLEAR];
   wire                       wr_k1   = wr_en && wr_sel[rcr_pkg::SEL_KEY1];
   wire                       wr_cfg  = wr_en && wr_sel[rcr_pkg::SEL_CFG];
   wire                       wr_k2   = wr_en && wr_sel[rcr_pkg::SEL_KEY2];
   wire                       k1_ok   = wr_k1 && (w_data_ff == rcr_pkg::KEY_FIRST);
   wire                       k2_ok   = wr_k2 && (w_data_ff == rcr_pkg::KEY_SECOND);

   assign awready = !aw_full_ff;
   assign wready  = !w_full_ff;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign arready = !rvalid_ff;
   assign rvalid  = rvalid_ff;
   assign rresp   = rresp_ff;
   assign rdata   = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Reset triggers; external wins, then watchdog, then software
   wire  sw_go    = wr_sta && w_data_ff[rcr_pkg::STA_SW];
   wire  ext_go   = ext_reset_req;
   wire  wdt_go   = wdt_timeout && !ext_go;
   wire  swr_go   = sw_go && !ext_go && !wdt_go;
   wire  any_go   = ext_go || wdt_go || swr_go;
   wire  commit   = (key_ff == rcr_pkg::KEY_HELD) && k2_ok;

   wire [2:0] clr_bits = wr_clr ? w_data_ff[2:0] : 3'h0;
   wire [2:0] set_bits = {swr_go, wdt_go, 1'b0};
   // Set wins over a clear arriving in the same cycle
   wire [2:0] nxt_status = ext_go ? 3'h0 : ((status_ff & ~clr_bits) | set_bits);

   wire [7:0] nxt_cfg = ext_go ? rcr_pkg::CFG_RST
                      : (commit ? pend_ff : cfg_ff);

   wire       nxt_mirror = any_go ? 1'b0
                         : (wr_mir ? w_data_ff[rcr_pkg::MIR_SRAM] : mirror_ff);

   wire [7:0] mir_view = {3'h0, fl32_ff, sr4_ff, dbg_ff, mirror_ff};

   wire [7:0] rd_byte = rd_sel[rcr_pkg::SEL_MIRROR] ? mir_view
                      : rd_sel[rcr_pkg::SEL_STATUS] ? {5'h0, status_ff}
                      : rd_sel[rcr_pkg::SEL_CFG]    ? cfg_ff
                      : 8'h00;
   wire       rd_hit  = |rd_sel;
   wire       wr_hit  = |wr_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Retention key sequence
   always_comb begin
      nxt_key = key_ff;
      unique case (key_ff)
         rcr_pkg::KEY_IDLE: begin
            if (k1_ok)
               nxt_key = rcr_pkg::KEY_ARMED;
         end
         rcr_pkg::KEY_ARMED: begin
            if (wr_cfg)
               nxt_key = rcr_pkg::KEY_HELD;
            else if (wr_k2 || (wr_k1 && !k1_ok))
               nxt_key = rcr_pkg::KEY_IDLE;
         end
         rcr_pkg::KEY_HELD: begin
            if (k1_ok)
               nxt_key = rcr_pkg::KEY_ARMED;
            else if (wr_k1 || wr_k2 || wr_cfg)
               nxt_key = rcr_pkg::KEY_IDLE;
         end
      endcase
      if (ext_go)
         nxt_key = rcr_pkg::KEY_IDLE;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_ff  <= rcr_pkg::KEY_IDLE;
         pend_ff <= rcr_pkg::CFG_RST;
         cfg_ff  <= rcr_pkg::CFG_RST;
      end else begin
         key_ff <= nxt_key;
         if (wr_cfg && key_ff == rcr_pkg::KEY_ARMED)
            pend_ff <= w_data_ff & rcr_pkg::CFG_MASK;
         cfg_ff <= nxt_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_ff <= 1'b0;
         w_full_ff  <= 1'b0;
         aw_addr_ff <= 32'h00000000;
         w_data_ff  <= 8'h00;
         w_lane_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= rcr_pkg::RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_full_ff <= 1'b1;
            aw_addr_ff <= awaddr;
         end
         if (w_hs) begin
            w_full_ff <= 1'b1;
            w_data_ff <= wdata[7:0];
            w_lane_ff <= wstrb[0];
         end
         if (wr_go) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_hit ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
         end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= rcr_pkg::RESP_OKAY;
         rdata_ff  <= 32'h00000000;
      end else if (ar_hs) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= rd_hit ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
         rdata_ff  <= {24'h000000, rd_byte};
      end else if (rvalid_ff && rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cause record and mirror bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= rcr_pkg::STATUS_POR;
         mirror_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         mirror_ff <= nxt_mirror;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset and boot sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_ff       <= rcr_pkg::SEQ_RESET;
         cnt_ff       <= rcr_pkg::RST_LAST;
         hold_gpio_ff <= 1'b0;
         hold_dac_ff  <= 1'b0;
         start_ff     <= 1'b0;
      end else begin
         start_ff <= 1'b0;
         if (any_go) begin
            seq_ff       <= rcr_pkg::SEQ_RESET;
            cnt_ff       <= rcr_pkg::RST_LAST;
            hold_gpio_ff <= !ext_go && cfg_ff[rcr_pkg::CFG_GPIO];
            hold_dac_ff  <= !ext_go && cfg_ff[rcr_pkg::CFG_DAC];
         end else begin
            unique case (seq_ff)
               rcr_pkg::SEQ_RESET: begin
                  if (cnt_ff == 8'h00) begin
                     seq_ff <= rcr_pkg::SEQ_KERNEL;
                     cnt_ff <= rcr_pkg::KRN_LAST;
                  end else begin
                     cnt_ff <= cnt_ff - 8'h01;
                  end
               end
               rcr_pkg::SEQ_KERNEL: begin
                  if (cnt_ff != 8'h00) begin
                     cnt_ff <= cnt_ff - 8'h01;
                  end else if (boot_mode_pin) begin
                     seq_ff   <= rcr_pkg::SEQ_RUN;
                     start_ff <= 1'b1;
                  end else begin
                     seq_ff <= rcr_pkg::SEQ_HALT;
                  end
               end
               rcr_pkg::SEQ_RUN: begin
                  seq_ff <= rcr_pkg::SEQ_RUN;
               end
               rcr_pkg::SEQ_HALT: begin
                  seq_ff <= rcr_pkg::SEQ_HALT;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Straps caught while the core is held, loaded as the kernel starts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_smp_ff <= 1'b0;
         dbg_ff      <= rcr_pkg::DBG_JTAG;
         fl32_ff     <= 1'b0;
         sr4_ff      <= 1'b0;
         vec_ff      <= rcr_pkg::USER_VECTOR;
      end else begin
         if (seq_ff == rcr_pkg::SEQ_RESET) begin
            boot_smp_ff <= boot_select_pin;
            fl32_ff     <= flash_reduced;
            sr4_ff      <= sram_reduced;
            if (cnt_ff == 8'h00 && !any_go)
               dbg_ff <= boot_smp_ff ? rcr_pkg::DBG_GPIO : rcr_pkg::DBG_JTAG;
         end
         vec_ff <= rcr_pkg::USER_VECTOR;
      end
   end

   assign core_reset       = (seq_ff == rcr_pkg::SEQ_RESET);
   assign gpio_reset       = core_reset && !hold_gpio_ff;
   assign dac_reset        = core_reset && !hold_dac_ff;
   assign kernel_active    = (seq_ff == rcr_pkg::SEQ_KERNEL) || (seq_ff == rcr_pkg::SEQ_HALT);
   assign user_start       = start_ff;
   assign user_vector      = vec_ff;
   assign sram_at_zero     = mirror_ff;
   assign debug_pin_select = dbg_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_remap_set_sram : assert property (@(posedge aclk) disable iff (!aresetn)
      wr_mir && w_data_ff[0] && !any_go |=> sram_at_zero)
      else $error("mirror set did not map SRAM");

   a_remap_back_flash : assert property (@(posedge aclk) disable iff (!aresetn)
      wr_mir && !w_data_ff[0] |=> !sram_at_zero)
      else $error("mirror clear did not map flash");

   a_reset_clears_mirror : assert property (@(posedge aclk) disable iff (!aresetn)
      any_go |=> core_reset && !sram_at_zero)
      else $error("reset left mirror set");

   a_debug_pin_load : assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(core_reset) && seq_ff == rcr_pkg::SEQ_KERNEL
      |-> debug_pin_select == ($past(boot_smp_ff) ? rcr_pkg::DBG_GPIO : rcr_pkg::DBG_JTAG))
      else $error("debug pin use not loaded");

   a_debug_pin_code : assert property (@(posedge aclk) disable iff (!aresetn)
      debug_pin_select[0] == 1'b0)
      else $error("debug pin code illegal");

   a_boot_jump_zero : assert property (@(posedge aclk) disable iff (!aresetn)
      user_start |-> $past(boot_mode_pin) && $past(kernel_active)
      && user_vector == rcr_pkg::USER_VECTOR ##1 !kernel_active && !user_start)
      else $error("user start without kernel");

   a_por_record : assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> status_ff == rcr_pkg::STATUS_POR && gpio_reset && dac_reset)
      else $error("power-on record wrong");

   a_wdt_record : assert property (@(posedge aclk) disable iff (!aresetn)
      wdt_go |=> status_ff[rcr_pkg::STA_WDT] && core_reset)
      else $error("watchdog cause not recorded");

   a_sw_force : assert property (@(posedge aclk) disable iff (!aresetn)
      swr_go |=> status_ff[rcr_pkg::STA_SW] && core_reset ##1 core_reset)
      else $error("software reset not forced");

   a_ext_null : assert property (@(posedge aclk) disable iff (!aresetn)
      ext_go |=> status_ff == 3'h0 && gpio_reset && dac_reset)
      else $error("external reset record wrong");

   a_clear_only_key : assert property (@(posedge aclk) disable iff (!aresetn)
      !wr_clr && !ext_go |=> (($past(status_ff) & ~status_ff) == 3'h0))
      else $error("status bit cleared without clear write");

   a_cfg_keyed : assert property (@(posedge aclk) disable iff (!aresetn)
      !commit && !ext_go |=> $stable(cfg_ff))
      else $error("retention changed without keys");

   a_gpio_kept : assert property (@(posedge aclk) disable iff (!aresetn)
      wdt_go && cfg_ff[rcr_pkg::CFG_GPIO] |=> core_reset && !gpio_reset)
      else $error("general I/O not retained");

   a_dac_kept : assert property (@(posedge aclk) disable iff (!aresetn)
      swr_go && cfg_ff[rcr_pkg::CFG_DAC] |=> core_reset && !dac_reset)
      else $error("analog outputs not retained");

endmodule : rcr_reset_remap

// ===== src/rcr_pkg.sv
// Package: constants and types for reset cause recording and low memory mirror
package rcr_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_MIRROR = 32'hffff0220;
   localparam logic [31:0] ADDR_STATUS = 32'hffff0230;
   localparam logic [31:0] ADDR_CLEAR  = 32'hffff0234;
   localparam logic [31:0] ADDR_KEY1   = 32'hffff0248;
   localparam logic [31:0] ADDR_CFG    = 32'hffff024c;
   localparam logic [31:0] ADDR_KEY2   = 32'hffff0250;

   // Register select one-hot positions
   localparam int unsigned SEL_MIRROR = 0;
   localparam int unsigned SEL_STATUS = 1;
   localparam int unsigned SEL_CLEAR  = 2;
   localparam int unsigned SEL_KEY1   = 3;
   localparam int unsigned SEL_CFG    = 4;
   localparam int unsigned SEL_KEY2   = 5;
   localparam int unsigned SEL_W      = 6;

   // Field positions
   localparam int unsigned MIR_SRAM   = 0;
   localparam int unsigned MIR_SRAM4K = 3;
   localparam int unsigned MIR_FL32K  = 4;
   localparam int unsigned STA_POR    = 0;
   localparam int unsigned STA_WDT    = 1;
   localparam int unsigned STA_SW     = 2;
   localparam int unsigned CFG_GPIO   = 0;
   localparam int unsigned CFG_DAC    = 2;

   // Reset values, masks and keys
   localparam logic [2:0] STATUS_POR  = 3'h1;
   localparam logic [7:0] CFG_RST     = 8'h00;
   localparam logic [7:0] CFG_MASK    = 8'h05;
   localparam logic [7:0] KEY_FIRST   = 8'h76;
   localparam logic [7:0] KEY_SECOND  = 8'hb1;
   localparam logic [1:0] DBG_JTAG    = 2'h0;
   localparam logic [1:0] DBG_GPIO    = 2'h2;
   localparam logic [31:0] USER_VECTOR = 32'h00000000;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sequence timing
   localparam int unsigned CLK_NS      = 25;
   localparam int unsigned RST_HOLD_NS = 1000;
   localparam int unsigned KERNEL_NS   = 2000;
   localparam logic [7:0] RST_LAST = 8'((RST_HOLD_NS + CLK_NS - 1) / CLK_NS - 1);
   localparam logic [7:0] KRN_LAST = 8'((KERNEL_NS + CLK_NS - 1) / CLK_NS - 1);

   typedef enum logic [3:0] {
      SEQ_RESET  = 4'b0001,
      SEQ_KERNEL = 4'b0010,
      SEQ_RUN    = 4'b0100,
      SEQ_HALT   = 4'b1000
   } rcr_seq_e;

   typedef enum logic [2:0] {
      KEY_IDLE  = 3'b001,
      KEY_ARMED = 3'b010,
      KEY_HELD  = 3'b100
   } rcr_key_e;
endpackage : rcr_pkg

// ===== test/test_rcr_reset_remap.sv
// Self-checking bench for the reset cause recorder and low memory mirror
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_rcr_reset_remap;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic [3:0]  wstrb = 4'h0, wr_strb = 4'h1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        ext_reset_req = 1'b0, wdt_timeout = 1'b0, boot_select_pin = 1'b0;
   logic        boot_mode_pin = 1'b1, flash_reduced = 1'b0, sram_reduced = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, core_reset, gpio_reset, dac_reset;
   logic        kernel_active, user_start, sram_at_zero, seen;
   logic [1:0]  bresp, rresp, debug_pin_select, resp;
   logic [31:0] rdata, user_vector, rd_val;
   int          error_cnt = 0, num_checks = 0, cyc = 0, n;

   always #12.5 aclk = ~aclk;

   rcr_reset_remap u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .ext_reset_req(ext_reset_req), .wdt_timeout(wdt_timeout),
      .boot_select_pin(boot_select_pin), .boot_mode_pin(boot_mode_pin),
      .flash_reduced(flash_reduced), .sram_reduced(sram_reduced), .core_reset(core_reset),
      .gpio_reset(gpio_reset), .dac_reset(dac_reset), .kernel_active(kernel_active),
      .user_start(user_start), .user_vector(user_vector), .sram_at_zero(sram_at_zero),
      .debug_pin_select(debug_pin_select));

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= wr_strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      #1;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      #1;
   endtask : rd

   // Read a register and compare data and response
   task automatic rc(input logic [31:0] a, input logic [7:0] e, input string nm);
      rd(a, rd_val, resp);
      `CHK(nm, {24'h0, e}, rd_val)
      `CHK("read resp", rcr_pkg::RESP_OKAY, resp)
   endtask : rc

   // Keyed retention update: first key, value, second key
   task automatic keyed_cfg(input logic [7:0] v);
      wr(rcr_pkg::ADDR_KEY1, rcr_pkg::KEY_FIRST, resp);
      wr(rcr_pkg::ADDR_CFG, v, resp);
      wr(rcr_pkg::ADDR_KEY2, rcr_pkg::KEY_SECOND, resp);
   endtask : keyed_cfg

   task automatic wait_boot();
      seen = 1'b0;
      n = 0;
      while (!seen && n < 400) begin
         @(posedge aclk);
         #1;
         if (user_start === 1'b1) seen = 1'b1;
         n++;
      end
      `CHK("user start", 1'b1, seen)
   endtask : wait_boot

   task automatic pulse_wdt();
      @(posedge aclk);
      wdt_timeout <= 1'b1;
      @(posedge aclk);
      wdt_timeout <= 1'b0;
      #1;
   endtask : pulse_wdt

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wait_boot();
      `CHK("vector", rcr_pkg::USER_VECTOR, user_vector)
      @(posedge aclk);
      #1;
      `CHK("kernel done", 1'b0, kernel_active)
      rc(rcr_pkg::ADDR_STATUS, 8'h01, "status por");
      rc(rcr_pkg::ADDR_CFG, 8'h00, "cfg reset");
      rc(rcr_pkg::ADDR_MIRROR, 8'h00, "mirror reset");
      rc(rcr_pkg::ADDR_CLEAR, 8'h00, "clear reads zero");
      wr(rcr_pkg::ADDR_MIRROR, 8'h01, resp);
      `CHK("write resp", rcr_pkg::RESP_OKAY, resp)
      `CHK("sram mapped", 1'b1, sram_at_zero)
      rc(rcr_pkg::ADDR_MIRROR, 8'h01, "mirror set");
      wr(rcr_pkg::ADDR_MIRROR, 8'h00, resp);
      `CHK("flash mapped", 1'b0, sram_at_zero)
      wr(rcr_pkg::ADDR_MIRROR, 8'h01, resp);
      keyed_cfg(8'h05);
      rc(rcr_pkg::ADDR_CFG, 8'h05, "cfg keyed");
      wr(rcr_pkg::ADDR_CFG, 8'h00, resp);
      wr(rcr_pkg::ADDR_KEY2, rcr_pkg::KEY_SECOND, resp);
      rc(rcr_pkg::ADDR_CFG, 8'h05, "cfg unkeyed");
      wr(32'hffff0224, 8'h01, resp);
      `CHK("unmapped write", rcr_pkg::RESP_SLVERR, resp)
      rd(32'hffff0224, rd_val, resp);
      `CHK("unmapped read", rcr_pkg::RESP_SLVERR, resp)
      // Write with byte lane 0 off has no effect
      wr_strb = 4'h0;
      wr(rcr_pkg::ADDR_MIRROR, 8'h00, resp);
      wr_strb = 4'h1;
      `CHK("masked write resp", rcr_pkg::RESP_OKAY, resp)
      `CHK("masked write", 1'b1, sram_at_zero)
      // Watchdog reset with both retention bits and changed straps
      @(posedge aclk);
      boot_select_pin <= 1'b1;
      flash_reduced <= 1'b1;
      sram_reduced <= 1'b1;
      pulse_wdt();
      `CHK("wdt core reset", 1'b1, core_reset)
      `CHK("gpio kept", 1'b0, gpio_reset)
      `CHK("dac kept", 1'b0, dac_reset)
      `CHK("mirror cleared", 1'b0, sram_at_zero)
      wait_boot();
      rc(rcr_pkg::ADDR_STATUS, 8'h03, "status wdt");
      rc(rcr_pkg::ADDR_MIRROR, 8'h1c, "mirror straps");
      `CHK("debug gpio", rcr_pkg::DBG_GPIO, debug_pin_select)
      wr(rcr_pkg::ADDR_STATUS, 8'h03, resp);
      rc(rcr_pkg::ADDR_STATUS, 8'h03, "status no self clear");
      wr(rcr_pkg::ADDR_CLEAR, 8'h01, resp);
      rc(rcr_pkg::ADDR_STATUS, 8'h02, "status clear one");
      wr(rcr_pkg::ADDR_CLEAR, 8'h07, resp);
      rc(rcr_pkg::ADDR_STATUS, 8'h00, "status clear all");
      // Software reset keeping analog outputs only
      keyed_cfg(8'h04);
      wr(rcr_pkg::ADDR_STATUS, 8'h04, resp);
      repeat (2) @(posedge aclk);
      #1;
      `CHK("sw core reset", 1'b1, core_reset)
      `CHK("sw gpio reset", 1'b1, gpio_reset)
      `CHK("sw dac kept", 1'b0, dac_reset)
      @(posedge aclk);
      boot_select_pin <= 1'b0;
      wait_boot();
      rc(rcr_pkg::ADDR_STATUS, 8'h04, "status sw");
      // External reset ignores retention and leaves status empty
      @(posedge aclk);
      ext_reset_req <= 1'b1;
      @(posedge aclk);
      ext_reset_req <= 1'b0;
      #1;
      `CHK("ext gpio reset", 1'b1, gpio_reset)
      `CHK("ext dac reset", 1'b1, dac_reset)
      wait_boot();
      rc(rcr_pkg::ADDR_STATUS, 8'h00, "status ext");
      rc(rcr_pkg::ADDR_CFG, 8'h00, "cfg ext");
      `CHK("debug jtag", rcr_pkg::DBG_JTAG, debug_pin_select)
      // Boot mode low keeps the kernel running with no jump
      @(posedge aclk);
      boot_mode_pin <= 1'b0;
      pulse_wdt();
      seen = 1'b0;
      repeat (200) begin
         @(posedge aclk);
         #1;
         if (user_start === 1'b1) seen = 1'b1;
      end
      `CHK("no user start", 1'b0, seen)
      `CHK("kernel held", 1'b1, kernel_active)
      complete_run();
   end
endmodule : test_rcr_reset_remap
